/* File: dv/rcl_regs_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module rcl_regs_monitor #(
  parameter integer CAL_CYCLES = 8 // calibration length
) (
  input wire logic        clock,             // clock
  input wire logic        reset,             // sync reset
  input wire logic        psel,              // apb select
  input wire logic        penable,           // apb access
  input wire logic        pwrite,            // apb write
  input wire logic [7:0]  paddr,             // apb address
  input wire logic [31:0] pwdata,            // apb write data
  input wire logic [31:0] prdata,            // apb read data
  input wire logic [7:0]  rate_divisor_high, // divisor upper byte
  input wire logic [15:0] rate_divisor,      // full divisor
  input wire logic        bit_tick,          // bit pulse
  input wire logic        osc_cal_busy,      // calibration running
  input wire logic [2:0]  current_mode,      // present mode
  input wire logic        receiver_on,       // receiver requested
  input wire logic        fifo_discard       // fifo drop pulse
);
  logic [31:0] cal_cnt; // cycles spent calibrating
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // count calibration cycles
  always_ff @(posedge clock) begin
    if (reset || !osc_cal_busy) cal_cnt <= 32'h0000_0000;
    else cal_cnt <= cal_cnt + 32'h0000_0001;
  end
  AST_RATE_HIGH: assert property (!$past(reset) |-> rate_divisor[15:8] == $past(rate_divisor_high))
    else $error("divisor upper byte not tracking input");
  AST_BIT_TICK: assert property ((bit_tick && rate_divisor > 16'h0001 && $stable(rate_divisor))
    |=> !bit_tick) else $error("bit tick lasted two cycles");
  AST_CAL_START: assert property ((psel && penable && pwrite && paddr == 8'h28 && pwdata[7])
    |=> osc_cal_busy) else $error("calibration did not start");
  AST_CAL_LEN: assert property (osc_cal_busy |-> cal_cnt < CAL_CYCLES)
    else $error("calibration ran too long");
  AST_CAL_END: assert property ($fell(osc_cal_busy) |-> $past(cal_cnt) == CAL_CYCLES - 1)
    else $error("calibration ended early");
  AST_CAL_READ: assert property ((psel && !penable && !pwrite && paddr == 8'h28)
    |=> prdata[7:0] == {1'b0, !$past(osc_cal_busy), 6'h01}) else $error("calibration readback");
  AST_MODE_RX: assert property (receiver_on == (current_mode == 3'h4))
    else $error("receiver flag disagrees with mode");
  AST_DISCARD_PULSE: assert property (fifo_discard |=> !fifo_discard)
    else $error("fifo discard longer than one cycle");
endmodule // rcl_regs_monitor
`default_nettype wire

/* File: dv/rcl_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, a, b); end end
module rcl_regs_test;
  localparam integer UNIT = 4; // cycles per fine unit
  localparam integer CAL  = 8; // calibration cycles
  logic        clock = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, rate_divisor_high = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, rv;
  logic        strength_above = 1'b0, sync_match = 1'b0, payload_complete = 1'b0;
  logic        rx_timeout = 1'b0, pready, pslverr, bit_tick, low_index_afc, osc_cal_busy;
  logic        receiver_on, fifo_discard, irq, err;
  logic [15:0] rate_divisor;
  logic [13:0] deviation_word;
  logic [23:0] carrier_word;
  logic [2:0]  current_mode;
  logic [7:0]  shadow [13];
  integer      compares = 0, n_fail = 0, cycles = 0, seed = 32'h0972, i, p, n, act;
  logic [7:0]  rst_tab [13] = '{8'h0b, 8'h00, 8'h52, 8'he4, 8'hc0, 8'h00, 8'h41,
                                8'h00, 8'h02, 8'h52, 8'hf5, 8'h20, 8'h10};
  logic [7:0]  wr_mask [13] = '{8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00,
                                8'h20, 8'h00, 8'hfe, 8'hff, 8'hff, 8'h00};

  rcl_regs #(.UNIT_FINE_CYCLES(UNIT), .CAL_CYCLES(CAL)) u_dut (
    .clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .rate_divisor_high, .strength_above, .sync_match, .payload_complete,
    .rx_timeout, .rate_divisor, .bit_tick, .deviation_word, .carrier_word,
    .low_index_afc, .osc_cal_busy, .current_mode, .receiver_on, .fifo_discard, .irq);

  // clock and hang guard, ceiling well above the ~18k cycles the tests need
  initial forever #2.5 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // expected readback after a write
  function automatic logic [7:0] expv(input integer k, input logic [7:0] d);
    return (d & wr_mask[k]) | (rst_tab[k] & ~wr_mask[k]);
  endfunction

  // one apb transfer and an idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, {24'h00_0000, e})
  endtask
  task automatic wait_rx(input logic lvl);
    integer k;
    k = 0;
    while (receiver_on !== lvl && k < 400) begin @(posedge clock); k++; end
    `CHK(receiver_on, lvl)
  endtask
  task automatic tally_and_finish();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    for (i = 0; i < 13; i++) rchk(8'h10 + 4 * i, rst_tab[i]);
    `CHK(carrier_word, 24'he4_c000)
    `CHK(deviation_word, 14'h0052)
    for (p = 0; p < 3; p++) for (i = 0; i < 13; i++) begin
      // bit 7 kept clear at the calibration slot so no calibration starts
      rv = $random(seed) & (i == 6 ? 32'h0000_007f : 32'h0000_00ff);
      rate_divisor_high <= $random(seed);
      shadow[i] = expv(i, rv[7:0]);
      apb(1'b1, 8'h10 + 4 * i, rv);
      rchk(8'h10 + 4 * i, shadow[i]);
    end
    `CHK(rate_divisor, {rate_divisor_high, shadow[0]})
    `CHK(deviation_word, {shadow[1][5:0], shadow[2]})
    `CHK(carrier_word, {shadow[3], shadow[4], shadow[5]})
    `CHK(low_index_afc, shadow[7][5])
    apb(1'b0, 8'h44, 32'h0000_0000);
    `CHK({rd, err}, {32'h0000_0000, 1'b1})
    apb(1'b1, 8'h11, 32'h0000_0077);
    rchk(8'h10, shadow[0]);
    // bit tick period equals divisor
    apb(1'b1, 8'h10, 32'h0000_0005);
    rate_divisor_high <= 8'h00;
    repeat (4) @(posedge clock);
    n = 0;
    repeat (100) begin @(posedge clock); n += bit_tick; end
    `CHK(n, 20)
    // calibration with interrupt
    apb(1'b1, 8'h88, 32'h0000_0000);
    apb(1'b1, 8'h84, 32'h0000_0007);
    `CHK(current_mode, 3'h1)
    apb(1'b1, 8'h28, 32'h0000_0080);
    rchk(8'h28, 8'h01);
    n = 0;
    while (osc_cal_busy === 1'b1 && n < 100) begin @(posedge clock); n++; end
    @(posedge clock);
    rchk(8'h28, 8'h41);
    `CHK(irq, 1'b0)
    apb(1'b1, 8'h88, 32'h0000_0001);
    `CHK(irq, 1'b1)
    apb(1'b1, 8'h84, 32'h0000_0001);
    `CHK(irq, 1'b0)
    // listen phase timing, no acceptance
    apb(1'b1, 8'h38, 32'h0000_0002);
    apb(1'b1, 8'h3c, 32'h0000_0003);
    apb(1'b1, 8'h34, 32'h0000_0052);
    apb(1'b1, 8'h80, 32'h0000_0044);
    wait_rx(1'b1);
    `CHK(current_mode, 3'h4)
    n = 0;
    while (receiver_on === 1'b1 && n < 500) begin @(posedge clock); n++; end
    `CHK(n, 3 * UNIT)
    n = 0;
    while (receiver_on === 1'b0 && n < 500) begin @(posedge clock); n++; end
    `CHK(n, 2 * UNIT)
    apb(1'b1, 8'h80, 32'h0000_0004);
    // post-accept actions with sync criterion
    for (act = 0; act < 3; act++) begin
      apb(1'b1, 8'h34, 32'h0000_0058 | (act << 1));
      strength_above <= 1'b1;
      sync_match <= 1'b0;
      apb(1'b1, 8'h80, 32'h0000_0044);
      wait_rx(1'b1);
      wait_rx(1'b0);
      sync_match <= 1'b1;
      wait_rx(1'b1);
      repeat (20) @(posedge clock);
      `CHK(receiver_on, 1'b1)
      payload_complete <= (act == 1);
      rx_timeout <= (act == 2);
      @(posedge clock);
      payload_complete <= 1'b0;
      rx_timeout <= 1'b0;
      repeat (3) @(posedge clock);
      if (act == 1) `CHK(current_mode, 3'h1)
      if (act == 2) begin
        n = 0;
        while (fifo_discard !== 1'b1 && n < 60) begin @(posedge clock); n++; end
        `CHK(fifo_discard, 1'b1)
      end
      strength_above <= 1'b0;
      rchk(8'h84, act == 2 ? 8'h02 : 8'h06);
      apb(1'b1, 8'h80, 32'h0000_0004);
      apb(1'b1, 8'h84, 32'h0000_0007);
      `CHK(current_mode, 3'h1)
    end
    // coarse idle unit, mid rx unit
    apb(1'b1, 8'h38, 32'h0000_0001);
    apb(1'b1, 8'h3c, 32'h0000_0001);
    apb(1'b1, 8'h34, 32'h0000_00e2);
    apb(1'b1, 8'h80, 32'h0000_0044);
    n = 0;
    while (receiver_on === 1'b0 && n < 20000) begin @(posedge clock); n++; end
    `CHK(n, 64 * 64 * UNIT + 1)
    n = 0;
    while (receiver_on === 1'b1 && n < 500) begin @(posedge clock); n++; end
    `CHK(n, 64 * UNIT)
    apb(1'b1, 8'h80, 32'h0000_0004);
    apb(1'b1, 8'h80, 32'h0000_000c);
    rchk(8'h80, 8'h0c);
    `CHK(current_mode, 3'h3)
    tally_and_finish();
  end
endmodule // rcl_regs_test

bind rcl_regs rcl_regs_monitor #(.CAL_CYCLES(CAL_CYCLES)) u_mon (
  .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .rate_divisor_high(rate_divisor_high),
  .rate_divisor(rate_divisor), .bit_tick(bit_tick), .osc_cal_busy(osc_cal_busy),
  .current_mode(current_mode), .receiver_on(receiver_on), .fifo_discard(fifo_discard));
`default_nettype wire

/* File: rtl/rcl_consts.vh */
`ifndef RCL_CONSTS_VH
`define RCL_CONSTS_VH
// register indices; byte address is four times the index
`define RCL_IDX_BIT_RATE_LOW      6'h04
`define RCL_IDX_DEVIATION_HIGH    6'h05
`define RCL_IDX_DEVIATION_LOW     6'h06
`define RCL_IDX_CARRIER_FREQ_HIGH 6'h07
`define RCL_IDX_CARRIER_FREQ_MID  6'h08
`define RCL_IDX_CARRIER_FREQ_LOW  6'h09
`define RCL_IDX_RC_OSC_CAL        6'h0a
`define RCL_IDX_AFC_CONTROL       6'h0b
`define RCL_IDX_RESERVED_SLOT     6'h0c
`define RCL_IDX_LISTEN_CONFIG     6'h0d
`define RCL_IDX_LISTEN_IDLE_COEF  6'h0e
`define RCL_IDX_LISTEN_RX_COEF    6'h0f
`define RCL_IDX_SILICON_REVISION  6'h10
`define RCL_IDX_LISTEN_CONTROL    6'h20
`define RCL_IDX_IRQ_STATUS        6'h21
`define RCL_IDX_IRQ_MASK          6'h22
// reset values
`define RCL_RST_BIT_RATE_LOW      8'h0b
`define RCL_RST_DEVIATION_HIGH    6'h00
`define RCL_RST_DEVIATION_LOW     8'h52
`define RCL_RST_CARRIER_HIGH      8'he4
`define RCL_RST_CARRIER_MID       8'hc0
`define RCL_RST_CARRIER_LOW       8'h00
`define RCL_RST_RESERVED_SLOT     8'h02
`define RCL_RST_IDLE_COEF         8'hf5
`define RCL_RST_RX_COEF           8'h20
`define RCL_RST_TIME_UNIT         2'b01
`define RCL_RST_POST_ACCEPT       2'b01
`define RCL_RST_MODE              3'b001
// field positions
`define RCL_BIT_CAL_TRIGGER       7
`define RCL_BIT_CAL_FINISHED      6
`define RCL_BIT_LOW_INDEX_AFC     5
`define RCL_BIT_DUTY_ENABLE       6
`define RCL_BIT_ACCEPT_TEST       3
// post-accept action codes
`define RCL_END_STAY_RX           2'b00
`define RCL_END_GO_MODE           2'b01
`define RCL_END_RESUME            2'b10
// operating modes
`define RCL_MODE_SLEEP            3'b000
`define RCL_MODE_STANDBY          3'b001
`define RCL_MODE_SYNTH            3'b010
`define RCL_MODE_TRANSMIT         3'b011
`define RCL_MODE_RECEIVE          3'b100
// interrupt status bits
`define RCL_IRQ_CAL_DONE          0
`define RCL_IRQ_ACCEPTED          1
`define RCL_IRQ_STOPPED           2
// timing
`define RCL_CLOCK_MHZ             200
`define RCL_UNIT_FINE_US          64
`define RCL_UNIT_FINE_CYCLES      (`RCL_UNIT_FINE_US * `RCL_CLOCK_MHZ)
`define RCL_UNIT_STEP             64
`define RCL_CAL_TIME_US           100
`define RCL_CAL_CYCLES            (`RCL_CAL_TIME_US * `RCL_CLOCK_MHZ)
`endif

/* File: rtl/rcl_regs.v */
// Behaviour
// R1 - hold rate divisor low byte, derive bit tick
// R2 - 14-bit deviation word, upper bits 5-0
// R3 - 24-bit carrier word over three bytes
// R4 - trigger starts calibration, done flag shows status
// R5 - software calibrates only in standby; the trigger starts calibration in any mode
// R6 - afc select picks improved or standard routine
// R7 - idle unit field selects 64us/4.1ms/262ms
// R8 - rx unit field uses same encoding
// R9 - accept test: strength, optionally sync match
// R10 - action 00: stay receive, listen stops
// R11 - action 01: wait end, go programmed mode
// R12 - action 10: wait end, resume idle, discard fifo
// R13 - idle phase equals coefficient times unit
// R14 - rx phase equals coefficient times unit
// R15 - revision reports full and metal numbers
// R16 - mode field encoding, read returns current mode
// R17 - software enables listen only in standby; the enable bit is accepted in any mode
// R18 - alternate idle and rx until accept or disable
`timescale 1ns/1ps
`default_nettype none
`include "rcl_consts.vh"
module rcl_regs #(
  parameter integer UNIT_FINE_CYCLES = `RCL_UNIT_FINE_CYCLES, // cycles per 64 us
  parameter integer CAL_CYCLES       = `RCL_CAL_CYCLES,       // calibration length
  parameter [3:0]   FULL_REVISION    = 4'h1,                  // arbitrary value
  parameter [3:0]   METAL_REVISION   = 4'h0                   // arbitrary value
) (
  input  wire        clock,              // 200 MHz clock
  input  wire        reset,              // sync reset, active high
  input  wire        psel,               // apb select
  input  wire        penable,            // apb access phase
  input  wire        pwrite,             // apb write
  input  wire [7:0]  paddr,              // apb byte address
  input  wire [31:0] pwdata,             // apb write data
  output wire        pready,             // apb ready
  output reg  [31:0] prdata,             // apb read data
  output wire        pslverr,            // apb unmapped access
  input  wire [7:0]  rate_divisor_high,  // divisor upper byte
  input  wire        strength_above,     // strength over strength_threshold
  input  wire        sync_match,         // sync address matched
  input  wire        payload_complete,   // payload complete event
  input  wire        rx_timeout,         // receive timeout event
  output reg  [15:0] rate_divisor,       // full bit-rate divisor
  output reg         bit_tick,           // one pulse per bit period
  output reg  [13:0] deviation_word,     // frequency deviation word
  output reg  [23:0] carrier_word,       // carrier frequency word
  output reg         low_index_afc,      // improved afc routine
  output reg         osc_cal_busy,       // rc calibration running
  output reg  [2:0]  current_mode,       // present operating mode
  output reg         receiver_on,        // receiver requested
  output reg         fifo_discard,       // pulse: drop fifo contents
  output wire        irq                 // level interrupt
);
  // listen states
  localparam [2:0] ST_OFF  = 3'd0;
  localparam [2:0] ST_IDLE = 3'd1;
  localparam [2:0] ST_RX   = 3'd2;
  localparam [2:0] ST_HOLD = 3'd3;
  localparam [2:0] ST_STOP = 3'd4;
  localparam integer STEP_LAST = `RCL_UNIT_STEP - 1;
  reg  [7:0]  bit_rate_low;
  reg  [5:0]  deviation_high;
  reg  [7:0]  deviation_low;
  reg  [7:0]  carrier_high;
  reg  [7:0]  carrier_mid;
  reg  [7:0]  carrier_low;
  reg         low_index_afc_select;
  reg  [1:0]  idle_time_unit;
  reg  [1:0]  rx_time_unit;
  reg         accept_test_select;
  reg  [1:0]  post_accept_action;
  reg  [7:0]  idle_phase_coef;
  reg  [7:0]  rx_phase_coef;
  reg         duty_cycle_enable;
  reg  [2:0]  mode_field;
  reg  [2:0]  irq_status;
  reg  [2:0]  irq_mask;
  reg         osc_cal_finished;
  reg  [31:0] cal_count;
  reg  [15:0] bit_count;
  reg  [31:0] fine_count;
  reg  [5:0]  mid_count;
  reg  [5:0]  coarse_count;
  reg  [7:0]  phase_count;
  reg  [2:0]  state;
  reg         discard_pending;
  reg         stop_in_rx;
  reg  [31:0] read_word;
  reg         mapped;
  reg  [2:0]  next_state;
  reg         ev_accept;
  reg         ev_stop;
  wire [5:0]  index     = paddr[7:2];
  wire        setup     = psel && !penable;
  wire        wr_strobe = psel && penable && pwrite && mapped;
  wire        fine_tick = (fine_count == UNIT_FINE_CYCLES - 1);
  wire        mid_tick  = fine_tick && (mid_count == STEP_LAST[5:0]);
  wire        coarse_tick = mid_tick && (coarse_count == STEP_LAST[5:0]);
  wire        cal_end   = osc_cal_busy && (cal_count == CAL_CYCLES - 1);
  // R9 acceptance test
  wire        accept    = strength_above && (!accept_test_select || sync_match);
  wire        end_event = payload_complete || rx_timeout;
  // R7 idle unit, 00 as fine
  wire        idle_tick = (idle_time_unit == 2'b11) ? coarse_tick :
                          (idle_time_unit == 2'b10) ? mid_tick : fine_tick;
  // R8 rx unit, same encoding
  wire        rx_tick   = (rx_time_unit == 2'b11) ? coarse_tick :
                          (rx_time_unit == 2'b10) ? mid_tick : fine_tick;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign irq     = |(irq_status & irq_mask);
  // read mux and address decode
  always @* begin
    read_word = 32'h0000_0000;
    mapped    = (paddr[1:0] == 2'b00);
    case (index)
      `RCL_IDX_BIT_RATE_LOW:      read_word[7:0] = bit_rate_low;
      `RCL_IDX_DEVIATION_HIGH:    read_word[7:0] = {2'b00, deviation_high};
      `RCL_IDX_DEVIATION_LOW:     read_word[7:0] = deviation_low;
      `RCL_IDX_CARRIER_FREQ_HIGH: read_word[7:0] = carrier_high;
      `RCL_IDX_CARRIER_FREQ_MID:  read_word[7:0] = carrier_mid;
      `RCL_IDX_CARRIER_FREQ_LOW:  read_word[7:0] = carrier_low;
      // R4 trigger reads zero, done flag in bit 6
      `RCL_IDX_RC_OSC_CAL:        read_word[7:0] = {1'b0, osc_cal_finished, 6'h01};
      `RCL_IDX_AFC_CONTROL:       read_word[7:0] = {2'b00, low_index_afc_select, 5'h00};
      `RCL_IDX_RESERVED_SLOT:     read_word[7:0] = `RCL_RST_RESERVED_SLOT;
      `RCL_IDX_LISTEN_CONFIG:     read_word[7:0] = {idle_time_unit, rx_time_unit,
                                                    accept_test_select, post_accept_action,
                                                    1'b0};
      `RCL_IDX_LISTEN_IDLE_COEF:  read_word[7:0] = idle_phase_coef;
      `RCL_IDX_LISTEN_RX_COEF:    read_word[7:0] = rx_phase_coef;
      // R15 revision nibbles
      `RCL_IDX_SILICON_REVISION:  read_word[7:0] = {FULL_REVISION, METAL_REVISION};
      // R16 read returns current mode
      `RCL_IDX_LISTEN_CONTROL:    read_word[7:0] = {1'b0, duty_cycle_enable,
                                                    1'b0, current_mode, 2'b00};
      `RCL_IDX_IRQ_STATUS:        read_word[2:0] = irq_status;
      `RCL_IDX_IRQ_MASK:          read_word[2:0] = irq_mask;
      default:                    mapped = 1'b0;
    endcase
  end
  // read data captured in the setup cycle
  always @(posedge clock) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= read_word;
    end
  end
  // software-written registers
  always @(posedge clock) begin
    if (reset) begin
      bit_rate_low         <= `RCL_RST_BIT_RATE_LOW;
      deviation_high       <= `RCL_RST_DEVIATION_HIGH;
      deviation_low        <= `RCL_RST_DEVIATION_LOW;
      carrier_high         <= `RCL_RST_CARRIER_HIGH;
      carrier_mid          <= `RCL_RST_CARRIER_MID;
      carrier_low          <= `RCL_RST_CARRIER_LOW;
      low_index_afc_select <= 1'b0;
      idle_time_unit       <= `RCL_RST_TIME_UNIT;
      rx_time_unit         <= `RCL_RST_TIME_UNIT;
      accept_test_select   <= 1'b0;
      post_accept_action   <= `RCL_RST_POST_ACCEPT;
      idle_phase_coef      <= `RCL_RST_IDLE_COEF;
      rx_phase_coef        <= `RCL_RST_RX_COEF;
      duty_cycle_enable    <= 1'b0;
      mode_field           <= `RCL_RST_MODE;
      irq_mask             <= 3'b000;
    end else if (wr_strobe) begin
      case (index)
        `RCL_IDX_BIT_RATE_LOW:      bit_rate_low <= pwdata[7:0];
        // R2 only bits 5-0 stored
        `RCL_IDX_DEVIATION_HIGH:    deviation_high <= pwdata[5:0];
        `RCL_IDX_DEVIATION_LOW:     deviation_low <= pwdata[7:0];
        `RCL_IDX_CARRIER_FREQ_HIGH: carrier_high <= pwdata[7:0];
        `RCL_IDX_CARRIER_FREQ_MID:  carrier_mid <= pwdata[7:0];
        `RCL_IDX_CARRIER_FREQ_LOW:  carrier_low <= pwdata[7:0];
        `RCL_IDX_AFC_CONTROL:       low_index_afc_select <= pwdata[`RCL_BIT_LOW_INDEX_AFC];
        `RCL_IDX_LISTEN_CONFIG: begin
          idle_time_unit     <= pwdata[7:6];
          rx_time_unit       <= pwdata[5:4];
          accept_test_select <= pwdata[`RCL_BIT_ACCEPT_TEST];
          post_accept_action <= pwdata[2:1];
        end
        `RCL_IDX_LISTEN_IDLE_COEF:  idle_phase_coef <= pwdata[7:0];
        `RCL_IDX_LISTEN_RX_COEF:    rx_phase_coef <= pwdata[7:0];
        `RCL_IDX_LISTEN_CONTROL: begin
          duty_cycle_enable <= pwdata[`RCL_BIT_DUTY_ENABLE];
          mode_field        <= pwdata[4:2];
        end
        `RCL_IDX_IRQ_MASK:          irq_mask <= pwdata[2:0];
        default: begin
        end
      endcase
    end
  end
  // configuration words driven out from flops
  always @(posedge clock) begin
    if (reset) begin
      rate_divisor   <= 16'h0000;
      deviation_word <= 14'h0000;
      carrier_word   <= 24'h00_0000;
      low_index_afc  <= 1'b0;
    end else begin
      // R1 full divisor
      rate_divisor   <= {rate_divisor_high, bit_rate_low};
      // R2 deviation word
      deviation_word <= {deviation_high, deviation_low};
      // R3 carrier word high to low
      carrier_word   <= {carrier_high, carrier_mid, carrier_low};
      // R6 afc routine select
      low_index_afc  <= low_index_afc_select;
    end
  end
  // R1 bit tick divider
  always @(posedge clock) begin
    if (reset) begin
      bit_count <= 16'h0000;
      bit_tick  <= 1'b0;
    end else if (bit_count + 16'h0001 >= rate_divisor) begin
      bit_count <= 16'h0000;
      bit_tick  <= 1'b1;
    end else begin
      bit_count <= bit_count + 16'h0001;
      bit_tick  <= 1'b0;
    end
  end
  // R4 calibration sequence
  always @(posedge clock) begin
    if (reset) begin
      osc_cal_busy     <= 1'b0;
      osc_cal_finished <= 1'b1;
      cal_count        <= 32'h0000_0000;
    end else if (wr_strobe && index == `RCL_IDX_RC_OSC_CAL &&
                 pwdata[`RCL_BIT_CAL_TRIGGER]) begin
      osc_cal_busy     <= 1'b1;
      osc_cal_finished <= 1'b0;
      cal_count        <= 32'h0000_0000;
    end else if (cal_end) begin
      osc_cal_busy     <= 1'b0;
      osc_cal_finished <= 1'b1;
    end else if (osc_cal_busy) begin
      cal_count <= cal_count + 32'h0000_0001;
    end
  end
  // listen timebase, 64 us then two steps of 64
  always @(posedge clock) begin
    if (reset || state == ST_OFF) begin
      fine_count   <= 32'h0000_0000;
      mid_count    <= 6'h00;
      coarse_count <= 6'h00;
    end else begin
      fine_count <= fine_tick ? 32'h0000_0000 : fine_count + 32'h0000_0001;
      if (fine_tick) begin
        mid_count <= mid_count + 6'h01;
      end
      if (mid_tick) begin
        coarse_count <= coarse_count + 6'h01;
      end
    end
  end
  // listen state decision
  always @* begin
    next_state = state;
    ev_accept  = 1'b0;
    ev_stop    = 1'b0;
    case (state)
      ST_OFF: next_state = ST_IDLE; // forced back to off below unless enabled
      // R13 idle phase length
      ST_IDLE: begin
        if (idle_tick && phase_count <= 8'h01) begin
          next_state = ST_RX;
        end
      end
      // R18 alternate phases
      ST_RX: begin
        if (accept) begin
          ev_accept = 1'b1;
          if (post_accept_action == `RCL_END_STAY_RX) begin
            next_state = ST_STOP;
            ev_stop    = 1'b1;
          end else begin
            next_state = ST_HOLD;
          end
        end else if (rx_tick && phase_count <= 8'h01) begin
          next_state = ST_IDLE;
        end
      end
      // R11 wait end event
      ST_HOLD: begin
        if (end_event) begin
          if (post_accept_action == `RCL_END_RESUME) begin
            next_state = ST_IDLE;
          end else begin
            next_state = ST_STOP;
            ev_stop    = 1'b1;
          end
        end
      end
      ST_STOP: next_state = ST_STOP;
      default: next_state = ST_OFF;
    endcase
    if (!duty_cycle_enable) begin
      next_state = ST_OFF;
    end
  end
  // listen state, phase counter and mode tracking
  always @(posedge clock) begin
    if (reset) begin
      state           <= ST_OFF;
      phase_count     <= 8'h00;
      discard_pending <= 1'b0;
      stop_in_rx      <= 1'b0;
      fifo_discard    <= 1'b0;
    end else begin
      state        <= next_state;
      fifo_discard <= 1'b0;
      if (next_state == ST_IDLE && state != ST_IDLE) begin
        phase_count <= idle_phase_coef;
      end else if (next_state == ST_RX && state != ST_RX) begin
        // R14 rx phase length
        phase_count <= rx_phase_coef;
      end else if ((state == ST_IDLE && idle_tick) || (state == ST_RX && rx_tick)) begin
        phase_count <= phase_count - 8'h01;
      end
      // R12 discard at next wakeup
      if (state == ST_HOLD && next_state == ST_IDLE) begin
        discard_pending <= 1'b1;
      end else if (next_state == ST_RX && state != ST_RX) begin
        discard_pending <= 1'b0;
        fifo_discard    <= discard_pending;
      end else if (next_state == ST_OFF) begin
        discard_pending <= 1'b0;
      end
      // R10 stop while staying in receive
      if (ev_stop) begin
        stop_in_rx <= (state == ST_RX);
      end
    end
  end
  // R16 current mode and receiver request
  always @(posedge clock) begin
    if (reset) begin
      current_mode <= `RCL_RST_MODE;
      receiver_on  <= 1'b0;
    end else if (next_state == ST_RX || next_state == ST_HOLD ||
                 (next_state == ST_STOP && (ev_stop ? state == ST_RX : stop_in_rx))) begin
      current_mode <= `RCL_MODE_RECEIVE;
      receiver_on  <= 1'b1;
    end else begin
      current_mode <= mode_field;
      receiver_on  <= (mode_field == `RCL_MODE_RECEIVE);
    end
  end
  // sticky status, set wins over write-one clear
  always @(posedge clock) begin
    if (reset) begin
      irq_status <= 3'b000;
    end else begin
      if (wr_strobe && index == `RCL_IDX_IRQ_STATUS) begin
        irq_status <= (irq_status & ~pwdata[2:0]) |
                      {ev_stop, ev_accept, cal_end};
      end else begin
        irq_status <= irq_status | {ev_stop, ev_accept, cal_end};
      end
    end
  end
endmodule // rcl_regs
`default_nettype wire
